// >>> tx_align_params.svh
`ifndef TX_ALIGN_PARAMS_SVH
`define TX_ALIGN_PARAMS_SVH
`define CLK_PERIOD_NS   10
`define CHAR_PERIOD_NS  160
`define CHAR_CYCLES     (`CHAR_PERIOD_NS / `CLK_PERIOD_NS)
`define RST_SAMPLES     2'h2
`define WSYNC_LEN       5'h10
`define BUF_DEPTH       4
`define LVL_CODE_LOW    2'h0
`define LVL_CODE_HIGH   2'h2
`define SPECIAL_CTRL    2'h1
`define WSYNC_CODE      8'hFF
`define VIOL_PREENC     10'h278
`define ADDR_CTRL       12'h000
`define ADDR_STATUS     12'h004
`define ADDR_INT_STAT   12'h008
`define ADDR_INT_MASK   12'h00C
`define CTRL_INIT_BIT   0
`define CTRL_OUTEN_BIT  1
`define CTRL_RESET      2'h2
`define IRQ_ERR_BIT     0
`define IRQ_RECNT_BIT   1
`define IRQ_INIT_BIT    2
`define IRQ_RESET       3'h0
`endif

// >>> tx_align_pkg.sv
`default_nettype none
package tx_align_pkg;
  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} level_t;
  typedef enum logic [1:0] {ST_INIT, ST_FILL, ST_RUN, ST_ERROR} buf_state_t;
  typedef enum logic [1:0] {KIND_RAW, KIND_ENCODE, KIND_VIOLATION, KIND_COMMA} kind_t;
  typedef struct packed {
    logic       sc_sel;
    logic [1:0] ctrl;
    logic [7:0] data;
  } in_char_t;
  typedef struct packed {
    kind_t      kind;
    logic       sc_sel;
    logic [9:0] code;
  } out_char_t;
endpackage
`default_nettype wire

// >>> bit_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module bit_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      o_q    <= '0;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule // bit_sync2
`default_nettype wire

// >>> phase_buf.sv
`timescale 1ns/10ps
`default_nettype none
module phase_buf #(
  parameter int W     = 11,
  parameter int DEPTH = 4,
  localparam int AW   = $clog2(DEPTH)
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_flush,
  input  wire logic         i_wr,
  input  wire logic [W-1:0] i_wdata,
  input  wire logic         i_rd,
  output logic      [W-1:0] o_rdata,
  output logic      [AW:0]  o_fill,
  output logic              o_ovf,
  output logic              o_unf
);
  localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);
  logic [W-1:0]  mem_r [DEPTH];
  logic [W-1:0]  mem_nxt [DEPTH];
  logic [AW:0]   wp_r, wp_nxt, rp_r, rp_nxt;
  logic [W-1:0]  rdata_r, rdata_nxt;
  logic          do_wr, do_rd;

  // Full and empty drive the slip flags; a flush hides them
  assign o_fill  = wp_r - rp_r;
  assign do_wr   = i_wr && (o_fill != DEPTH_W);
  assign do_rd   = i_rd && (o_fill != '0);
  assign o_ovf   = i_wr && !do_wr && !i_flush;
  assign o_unf   = i_rd && !do_rd && !i_flush;
  assign o_rdata = rdata_r;

  // Pointer and storage next values
  always_comb begin
    mem_nxt   = mem_r;
    wp_nxt    = wp_r;
    rp_nxt    = rp_r;
    rdata_nxt = rdata_r;
    if (i_flush) begin
      wp_nxt = '0;
      rp_nxt = '0;
    end else begin
      if (do_wr) begin
        mem_nxt[wp_r[AW-1:0]] = i_wdata;
        wp_nxt = wp_r + 1'b1;
      end
      if (do_rd) begin
        rdata_nxt = mem_r[rp_r[AW-1:0]];
        rp_nxt    = rp_r + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wp_r    <= '0;
      rp_r    <= '0;
      rdata_r <= '0;
    end else begin
      mem_r   <= mem_nxt;
      wp_r    <= wp_nxt;
      rp_r    <= rp_nxt;
      rdata_r <= rdata_nxt;
    end
  end
endmodule // phase_buf
`default_nettype wire

// >>> tx_input_phase_align.sv
`timescale 1ns/10ps
`default_nettype none
`include "tx_align_params.svh"
module tx_input_phase_align #(
  parameter int DEPTH    = `BUF_DEPTH,
  parameter int CHAR_CYC = `CHAR_CYCLES
) (
  input  wire logic                   I_CLOCK,
  input  wire logic                   I_RST_B,
  input  wire logic                   I_PSEL,
  input  wire logic                   I_PENABLE,
  input  wire logic                   I_PWRITE,
  input  wire logic [11:0]            I_PADDR,
  input  wire logic [31:0]            I_PWDATA,
  output logic      [31:0]            O_PRDATA,
  output logic                        O_PREADY,
  output logic                        O_PSLVERR,
  input  wire logic                   I_INPUT_CLK,
  input  wire logic [7:0]             I_TX_DATA,
  input  wire logic [1:0]             I_TX_CONTROL_BITS,
  input  wire logic                   I_SPECIAL_CHAR_SELECT,
  input  wire logic [3:0]             I_TX_MODE_SELECT,
  input  wire logic [1:0]             I_INPUT_CLOCK_SELECT,
  input  wire logic                   I_INPUT_RATE_SELECT,
  input  wire logic                   I_TRANSMIT_RESET_IN,
  output tx_align_pkg::out_char_t     O_CHAR,
  output logic                        O_CHAR_VALID,
  output logic                        O_TRANSMIT_ERROR_OUT,
  output logic      [3:0]             O_TX_MODE,
  output logic                        O_IRQ
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CENTER = (AW+1)'(DEPTH / 2);

  // Three level pin code: open reads as mid
  function automatic tx_align_pkg::level_t lvl_decode(input logic [1:0] c);
    if (c == `LVL_CODE_LOW) begin
      return tx_align_pkg::LVL_LOW;
    end else if (c == `LVL_CODE_HIGH) begin
      return tx_align_pkg::LVL_HIGH;
    end
    return tx_align_pkg::LVL_MID;
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  logic [19:0]              s_vec;
  logic                     s_inclk, s_rst, s_rate, s_scs;
  logic [1:0]               s_ctrl, s_cksel;
  logic [7:0]               s_data;
  logic [3:0]               s_mode;
  tx_align_pkg::level_t     mode_up, mode_lo;
  logic                     bypass, enc_en, sc_en, tick, rise, fall, cap;
  logic [7:0]               tick_cnt_r, tick_cnt_nxt;
  logic                     inclk_d_r, tick_d_r, rd_d_r, cap_d_r;
  tx_align_pkg::in_char_t   in_r, in_nxt, src, buf_rdata;
  logic [AW:0]              fill;
  logic                     ovf, unf, rd, wr, flush, out_go;
  logic                     init_cond, wsync_start, recenter;
  logic [1:0]               rst_cnt_r, rst_cnt_nxt;
  logic [4:0]               wsync_cnt_r, wsync_cnt_nxt;
  tx_align_pkg::buf_state_t state_r, state_nxt;
  logic                     err_out_r, err_out_nxt;
  tx_align_pkg::out_char_t  out_r, out_nxt;
  logic                     valid_r, valid_nxt;
  logic [3:0]               mode_r, mode_nxt;
  logic [1:0]               ctrl_r, ctrl_nxt;
  logic [2:0]               istat_r, istat_nxt, imask_r, imask_nxt, ev;
  logic [31:0]              prdata_r, prdata_nxt;
  logic                     setup, wr_acc, mapped;

  // Every pin from the host side passes two flops
  bit_sync2 #(.W(20)) u_pin_sync (
    .i_clk   (I_CLOCK),
    .i_rst_b (I_RST_B),
    .i_d     ({I_INPUT_CLK, I_TRANSMIT_RESET_IN, I_INPUT_RATE_SELECT, I_INPUT_CLOCK_SELECT,
               I_TX_MODE_SELECT, I_SPECIAL_CHAR_SELECT, I_TX_CONTROL_BITS, I_TX_DATA}),
    .o_q     (s_vec)
  );
  assign {s_inclk, s_rst, s_rate, s_cksel, s_mode, s_scs, s_ctrl, s_data} = s_vec;

  // Mode decode
  assign mode_up = lvl_decode(s_mode[3:2]);
  assign mode_lo = lvl_decode(s_mode[1:0]);
  assign enc_en  = (mode_up != tx_align_pkg::LVL_LOW);
  assign sc_en   = (mode_lo != tx_align_pkg::LVL_HIGH);
  assign bypass  = (lvl_decode(s_cksel) == tx_align_pkg::LVL_LOW) && !s_rate;

  // Character tick from the reference clock; input clock edges from samples
  assign tick = (tick_cnt_r == 8'(CHAR_CYC - 1));
  assign rise = s_inclk && !inclk_d_r;
  assign fall = !s_inclk && inclk_d_r;
  assign cap  = bypass ? tick : (s_rate ? (rise || fall) : rise);

  always_comb begin
    tick_cnt_nxt = tick ? 8'h00 : tick_cnt_r + 8'h01;
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tick_cnt_r <= 8'h00;
      inclk_d_r  <= 1'b0;
      tick_d_r   <= 1'b0;
      rd_d_r     <= 1'b0;
      cap_d_r    <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      inclk_d_r  <= s_inclk;
      tick_d_r   <= tick;
      rd_d_r     <= rd;
      cap_d_r    <= cap;
    end
  end

  // Input register; select is kept only where the mode reads it
  always_comb begin
    in_nxt = in_r;
    if (cap) begin
      in_nxt.data   = s_data;
      in_nxt.ctrl   = s_ctrl;
      in_nxt.sc_sel = s_scs && sc_en;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      in_r <= '0;
    end else begin
      in_r <= in_nxt;
    end
  end

  // Buffer traffic; the centre depth leaves slack well over half a character
  assign wr    = cap_d_r && !bypass;
  assign rd    = tick && !bypass && ((state_r == tx_align_pkg::ST_RUN) ||
                 (state_r == tx_align_pkg::ST_ERROR));
  assign flush = init_cond || recenter;

  phase_buf #(.W(11), .DEPTH(DEPTH)) u_buf (
    .i_clk   (I_CLOCK),
    .i_rst_b (I_RST_B),
    .i_flush (flush),
    .i_wr    (wr),
    .i_wdata (in_r),
    .i_rd    (rd),
    .o_rdata (buf_rdata),
    .o_fill  (fill),
    .o_ovf   (ovf),
    .o_unf   (unf)
  );

  assign src         = bypass ? in_r : buf_rdata;
  assign out_go      = tick_d_r && (bypass || rd_d_r || (wsync_cnt_r != 5'h00));
  assign wsync_start = out_go && enc_en && (wsync_cnt_r == 5'h00) &&
                       (src.ctrl == `SPECIAL_CTRL) && (src.data == `WSYNC_CODE);
  assign recenter    = wsync_start && (mode_up == tx_align_pkg::LVL_MID) &&
                       (state_r == tx_align_pkg::ST_ERROR);
  assign init_cond   = (rst_cnt_r == `RST_SAMPLES) || ctrl_r[`CTRL_INIT_BIT];

  // Control state: init wins, then slip, then recentre
  always_comb begin
    rst_cnt_nxt = s_rst ? 2'h0 : ((rst_cnt_r == `RST_SAMPLES) ? rst_cnt_r : rst_cnt_r + 2'h1);
    wsync_cnt_nxt = wsync_cnt_r;
    if (wsync_start) begin
      wsync_cnt_nxt = `WSYNC_LEN - 5'h01;
    end else if (out_go && (wsync_cnt_r != 5'h00)) begin
      wsync_cnt_nxt = wsync_cnt_r - 5'h01;
    end
    state_nxt = state_r;
    unique case (state_r)
      tx_align_pkg::ST_INIT: begin
        state_nxt = tx_align_pkg::ST_FILL;
      end
      tx_align_pkg::ST_FILL: begin
        if (fill >= CENTER) begin
          state_nxt = tx_align_pkg::ST_RUN;
        end
      end
      tx_align_pkg::ST_RUN: begin
        if (ovf || unf) begin
          state_nxt = tx_align_pkg::ST_ERROR;
        end
      end
      tx_align_pkg::ST_ERROR: begin
        if (recenter) begin
          state_nxt = tx_align_pkg::ST_FILL;
        end
      end
    endcase
    if (init_cond) begin
      state_nxt = tx_align_pkg::ST_INIT;
    end
    err_out_nxt = (state_r == tx_align_pkg::ST_ERROR) && !bypass;
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_cnt_r   <= 2'h0;
      wsync_cnt_r <= 5'h00;
      state_r     <= tx_align_pkg::ST_INIT;
      err_out_r   <= 1'b0;
    end else begin
      rst_cnt_r   <= rst_cnt_nxt;
      wsync_cnt_r <= wsync_cnt_nxt;
      state_r     <= state_nxt;
      err_out_r   <= err_out_nxt;
    end
  end

  // Output character; commas of a running sync beat the violation fill
  always_comb begin
    out_nxt   = out_r;
    valid_nxt = out_go && ctrl_r[`CTRL_OUTEN_BIT];
    mode_nxt  = {2'h0, mode_up} * 4'h3 + {2'h0, mode_lo};
    if (out_go) begin
      out_nxt.sc_sel = 1'b0;
      out_nxt.code   = {src.ctrl, src.data};
      if (wsync_start || (wsync_cnt_r != 5'h00)) begin
        out_nxt.kind = tx_align_pkg::KIND_COMMA;
        out_nxt.code = 10'h000;
      end else if (state_r == tx_align_pkg::ST_ERROR && !bypass) begin
        out_nxt.kind = tx_align_pkg::KIND_VIOLATION;
        out_nxt.code = enc_en ? 10'h000 : `VIOL_PREENC;
      end else if (!enc_en) begin
        out_nxt.kind = tx_align_pkg::KIND_RAW;
      end else begin
        out_nxt.kind   = tx_align_pkg::KIND_ENCODE;
        out_nxt.sc_sel = src.sc_sel;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      out_r   <= '0;
      valid_r <= 1'b0;
      mode_r  <= 4'h0;
    end else begin
      out_r   <= out_nxt;
      valid_r <= valid_nxt;
      mode_r  <= mode_nxt;
    end
  end

  // APB slave with zero wait states; read data is staged in the setup cycle
  assign setup  = I_PSEL && !I_PENABLE;
  assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
  assign mapped = hit(I_PADDR, `ADDR_CTRL) || hit(I_PADDR, `ADDR_STATUS) ||
                  hit(I_PADDR, `ADDR_INT_STAT) || hit(I_PADDR, `ADDR_INT_MASK);
  assign ev[`IRQ_ERR_BIT]   = (state_r == tx_align_pkg::ST_RUN) &&
                              (state_nxt == tx_align_pkg::ST_ERROR);
  assign ev[`IRQ_RECNT_BIT] = recenter;
  assign ev[`IRQ_INIT_BIT]  = (state_r == tx_align_pkg::ST_INIT) &&
                              (state_nxt == tx_align_pkg::ST_FILL);

  // Sticky status: a new event beats a write-one clear in the same cycle
  always_comb begin
    ctrl_nxt   = ctrl_r;
    imask_nxt  = imask_r;
    istat_nxt  = istat_r | ev;
    prdata_nxt = prdata_r;
    if (wr_acc && hit(I_PADDR, `ADDR_CTRL)) begin
      ctrl_nxt = I_PWDATA[1:0];
    end
    if (wr_acc && hit(I_PADDR, `ADDR_INT_MASK)) begin
      imask_nxt = I_PWDATA[2:0];
    end
    if (wr_acc && hit(I_PADDR, `ADDR_INT_STAT)) begin
      istat_nxt = (istat_r & ~I_PWDATA[2:0]) | ev;
    end
    if (setup) begin
      prdata_nxt = 32'h0000_0000;
      if (hit(I_PADDR, `ADDR_CTRL)) begin
        prdata_nxt = {30'h0, ctrl_r};
      end
      if (hit(I_PADDR, `ADDR_STATUS)) begin
        prdata_nxt = 32'({wsync_cnt_r != 5'h00, bypass, state_r, fill});
      end
      if (hit(I_PADDR, `ADDR_INT_STAT)) begin
        prdata_nxt = {29'h0, istat_r};
      end
      if (hit(I_PADDR, `ADDR_INT_MASK)) begin
        prdata_nxt = {29'h0, imask_r};
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_r   <= `CTRL_RESET;
      imask_r  <= `IRQ_RESET;
      istat_r  <= `IRQ_RESET;
      prdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r   <= ctrl_nxt;
      imask_r  <= imask_nxt;
      istat_r  <= istat_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign O_PRDATA             = prdata_r;
  assign O_PREADY             = 1'b1;
  assign O_PSLVERR            = I_PSEL && I_PENABLE && !mapped;
  assign O_CHAR               = out_r;
  assign O_CHAR_VALID         = valid_r;
  assign O_TRANSMIT_ERROR_OUT = err_out_r;
  assign O_TX_MODE            = mode_r;
  assign O_IRQ                = |(istat_r & imask_r);

  // Checks on the design's own behaviour
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);

  property p_two_low_init;
    !s_rst ##1 !s_rst |=> ##1 state_r == tx_align_pkg::ST_INIT; // Counter lands one edge later
  endproperty
  a_two_low_init: assert property (p_two_low_init) else $error("init missed");

  property p_center_run;
    (state_r == tx_align_pkg::ST_FILL && fill >= CENTER && !init_cond)
      |=> state_r == tx_align_pkg::ST_RUN;
  endproperty
  a_center_run: assert property (p_center_run) else $error("no run at centre");

  property p_slip_err;
    (state_r == tx_align_pkg::ST_RUN && (ovf || unf) && !init_cond)
      |=> ##1 O_TRANSMIT_ERROR_OUT || $past(bypass);
  endproperty
  a_slip_err: assert property (p_slip_err) else $error("slip not flagged");

  property p_err_hold;
    (state_r == tx_align_pkg::ST_ERROR && !init_cond && !recenter)
      |=> state_r == tx_align_pkg::ST_ERROR;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error dropped");

  property p_viol_fill;
    (out_go && state_r == tx_align_pkg::ST_ERROR && !bypass && wsync_cnt_r == 5'h00 &&
     !wsync_start) |=> O_CHAR.kind == tx_align_pkg::KIND_VIOLATION;
  endproperty
  a_viol_fill: assert property (p_viol_fill) else $error("user char in error");

  property p_recenter;
    recenter && !init_cond |=> state_r == tx_align_pkg::ST_FILL ##1 !O_TRANSMIT_ERROR_OUT;
  endproperty
  a_recenter: assert property (p_recenter) else $error("sync did not recentre");

  property p_sync_len;
    wsync_start |=> wsync_cnt_r == 5'h0F;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("bad sync length");

  property p_bypass_quiet;
    O_TRANSMIT_ERROR_OUT |-> !$past(bypass);
  endproperty
  a_bypass_quiet: assert property (p_bypass_quiet) else $error("error in bypass");

  property p_bypass_cap;
    (bypass && tick) |=> in_r.data == $past(s_data) && in_r.ctrl == $past(s_ctrl);
  endproperty
  a_bypass_cap: assert property (p_bypass_cap) else $error("bypass capture lost");

  property p_raw_code;
    (out_go && !enc_en && wsync_cnt_r == 5'h00 && state_r != tx_align_pkg::ST_ERROR)
      |=> O_CHAR.kind == tx_align_pkg::KIND_RAW && O_CHAR.code == $past({src.ctrl, src.data});
  endproperty
  a_raw_code: assert property (p_raw_code) else $error("raw code wrong");

  c_error: cover property (state_r == tx_align_pkg::ST_RUN ##1 state_r == tx_align_pkg::ST_ERROR);
  c_recenter: cover property (recenter);
  c_sync_done: cover property (wsync_cnt_r == 5'h01 && out_go);
  c_bypass_char: cover property (bypass && valid_r);
endmodule // tx_input_phase_align
`default_nettype wire

// >>> tx_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module tx_host_model (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_run,
  input  wire logic                   i_init,
  input  wire tx_align_pkg::in_char_t i_char,
  output logic                        o_input_clk,
  output tx_align_pkg::in_char_t      o_char,
  output logic                        o_transmit_reset_in
);
  // Free of drift, 160 ns period; stands low while the host stalls
  // Data launches on the falling edge so it is settled at the rising one
  initial begin
    o_input_clk = 1'b0;
    o_char      = '0;
    #3;
    forever begin
      #80;
      if (o_input_clk) begin
        o_char <= i_char;
      end
      o_input_clk <= i_run ? ~o_input_clk : 1'b0;
    end
  end
  // Reset request lasts as long as the bench holds init, which is well over two clock samples
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_transmit_reset_in <= 1'b1;
    end else begin
      o_transmit_reset_in <= ~i_init;
    end
  end
endmodule // tx_host_model
`default_nettype wire

// >>> tx_input_phase_align_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "tx_align_params.svh"
module tx_input_phase_align_test;
  logic                    clk = 1'b0;
  logic                    rst_b = 1'b0;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [11:0]             paddr = '0;
  logic [31:0]             pwdata = '0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    input_clk;
  tx_align_pkg::in_char_t  tx_char;
  tx_align_pkg::in_char_t  host_char = '0;
  logic [3:0]              mode = 4'h0;
  logic [1:0]              clk_sel = 2'h0;
  logic                    rate_sel = 1'b0;
  logic                    trst;
  logic                    run = 1'b1;
  logic                    init = 1'b0;
  tx_align_pkg::out_char_t out_char;
  logic                    out_valid;
  logic                    err_out;
  logic [3:0]              tx_mode;
  logic                    irq;
  logic [31:0]             r;
  logic                    e;
  int                      mismatches = 0;
  int                      checked = 0;
  int                      n;

  tx_input_phase_align tx_input_phase_align_i (
    .I_CLOCK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_INPUT_CLK(input_clk),
    .I_TX_DATA(tx_char.data), .I_TX_CONTROL_BITS(tx_char.ctrl),
    .I_SPECIAL_CHAR_SELECT(tx_char.sc_sel), .I_TX_MODE_SELECT(mode),
    .I_INPUT_CLOCK_SELECT(clk_sel), .I_INPUT_RATE_SELECT(rate_sel),
    .I_TRANSMIT_RESET_IN(trst), .O_CHAR(out_char), .O_CHAR_VALID(out_valid),
    .O_TRANSMIT_ERROR_OUT(err_out), .O_TX_MODE(tx_mode), .O_IRQ(irq));

  tx_host_model tx_host_model_i (
    .i_clk(clk), .i_rst_b(rst_b), .i_run(run), .i_init(init), .i_char(host_char),
    .o_input_clk(input_clk), .o_char(tx_char), .o_transmit_reset_in(trst));

  // 100 MHz reference clock
  always #5 clk = ~clk;

  task automatic conclude;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_kind(input tx_align_pkg::kind_t k);
    checked++;
    if (out_char.kind !== k) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, out_char.kind, k);
    end
  endtask

  // A wait that runs out counts as a mismatch and ends the run
  task automatic give_up;
    cmp(32'h0, 32'h1);
    conclude();
  endtask

  // Setup then access; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (k > 20) give_up();
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Valid lasts one cycle; the edge sees the value that stood before it
  task automatic get_char(input int cnt);
    int k;
    repeat (cnt) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
        if (k > 400) give_up();
      end while (out_valid !== 1'b1);
    end
  endtask

  task automatic wait_err;
    int k;
    k = 0;
    while (err_out !== 1'b1) begin
      @(posedge clk);
      k++;
      if (k > 2000) give_up();
    end
  endtask

  function automatic logic [1:0] lv(input int i);
    return (i == 0) ? 2'h0 : ((i == 1) ? 2'h1 : 2'h2);
  endfunction

  initial begin
    repeat (60000) @(posedge clk);
    give_up();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, `ADDR_CTRL, 32'h0);
    cmp(r, 32'h2);
    apb(1'b0, `ADDR_INT_MASK, 32'h0);
    cmp(r, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    cmp({r[30:0], e}, 32'h1);
    $display("test registers done");
    // All nine mode pairs
    for (int u = 0; u < 3; u++) begin
      for (int l = 0; l < 3; l++) begin
        mode <= {lv(u), lv(l)};
        repeat (4) @(posedge clk);
        cmp(32'(tx_mode), 32'(3 * u + l));
      end
    end
    $display("test modes done");
    mode <= 4'h0;
    host_char <= '{1'b1, 2'h2, 8'h5A};
    get_char(4);
    cmp(32'(out_char.code), 32'h25A);
    cmp_kind(tx_align_pkg::KIND_RAW);
    cmp(32'(err_out), 32'h0);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    cmp(32'(r[5]), 32'h1);
    mode <= 4'h8;
    get_char(3);
    cmp_kind(tx_align_pkg::KIND_ENCODE);
    cmp(32'(out_char.sc_sel), 32'h1);
    mode <= 4'hA;
    get_char(3);
    cmp(32'(out_char.sc_sel), 32'h0);
    $display("test bypass done");
    mode <= 4'h0;
    clk_sel <= 2'h1;
    init <= 1'b1;
    repeat (6) @(posedge clk);
    init <= 1'b0;
    get_char(4);
    cmp(32'(out_char.code), 32'h25A);
    cmp(32'(err_out), 32'h0);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    cmp(32'(r[5:3]), 32'h2);
    $display("test buffer done");
    // Host stalls: the buffer runs dry
    apb(1'b1, `ADDR_INT_MASK, 32'h0);
    run <= 1'b0;
    wait_err();
    cmp(32'(irq), 32'h0);
    apb(1'b0, `ADDR_INT_STAT, 32'h0);
    cmp(32'(r[0]), 32'h1);
    apb(1'b1, `ADDR_INT_MASK, 32'h1);
    @(posedge clk);
    cmp(32'(irq), 32'h1);
    get_char(2);
    cmp_kind(tx_align_pkg::KIND_VIOLATION);
    cmp(32'(out_char.code), 32'h278);
    run <= 1'b1;
    repeat (300) @(posedge clk);
    cmp(32'(err_out), 32'h1);
    clk_sel <= 2'h0;
    repeat (4) @(posedge clk);
    cmp(32'(err_out), 32'h0);
    clk_sel <= 2'h1;
    repeat (4) @(posedge clk);
    cmp(32'(err_out), 32'h1);
    apb(1'b1, `ADDR_INT_STAT, 32'h1);
    @(posedge clk);
    cmp(32'(irq), 32'h0);
    $display("test error done");
    // Word sync in atomic mode recentres the buffer
    mode <= 4'h4;
    host_char <= '{1'b0, 2'h1, 8'hFF};
    n = 0;
    do begin
      get_char(1);
      n++;
      if (n > 100) give_up();
    end while (out_char.kind !== tx_align_pkg::KIND_COMMA);
    host_char <= '{1'b0, 2'h0, 8'h33};
    n = 1;
    get_char(1);
    while (out_char.kind === tx_align_pkg::KIND_COMMA && n < 40) begin
      n++;
      get_char(1);
    end
    cmp(32'(n), 32'h10);
    cmp(32'(err_out), 32'h0);
    apb(1'b0, `ADDR_INT_STAT, 32'h0);
    cmp(32'(r[1]), 32'h1);
    $display("test word sync done");
    // Soft init with the output gate off: no characters, buffer held in init
    apb(1'b1, `ADDR_CTRL, 32'h1);
    @(posedge clk);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (out_valid !== 1'b0) n++;
    end
    cmp(32'(n), 32'h0);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    cmp(32'(r[4:3]), 32'h0);
    apb(1'b1, `ADDR_CTRL, 32'h2);
    // Rate select alone still routes through the buffer
    clk_sel <= 2'h0;
    rate_sel <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    cmp(32'(r[5]), 32'h0);
    $display("test control done");
    conclude();
  end
endmodule // tx_input_phase_align_test
`default_nettype wire
